// >>> rtl/qdc_top.sv
// Quadrature decoder: register slave, pin ownership, decoding, accumulators
// Function
// R1 - Route phase one, phase two and lamp to pins named by selects
// R2 - Connect bit set leaves that signal attached to no pin
// R3 - Pin selects act only while the decoder is enabled
// R4 - Disabled decoder hands pins back to general-purpose output logic
// R5 - Software sets chosen pins as inputs before enabling
// R6 - Software gives each pin to one driver at a time
// R7 - Start begins decoding; latest sample refreshed each sample interval
// R8 - Stop halts decoding and raises the halted flag
// R9 - Both-snapshot copies both totals then clears both
// R10 - Motion snapshot copies and clears only the motion total
// R11 - Double snapshot copies and clears only the double count
// R12 - Snapshot and clear are indivisible; no sample lost or doubled
// R13 - Sample-ready flag set on every new latest sample
// R14 - Report interval sets samples before report and double events
// R15 - Overflow flag raised when either total would overflow
// R16 - Shortcut bits let events fire tasks without software
// R17 - Enable register turns decoder on and takes the pins
// R18 - Lead time sets how long lamp is on before sampling
// R19 - Polarity register selects lamp active level
// R20 - Filter enable turns on debounce on both phases
// R21 - Compare pairs: step gives plus or minus one, both change gives 2
// R22 - Total adds steps only; double count adds one per double
// R23 - Out-of-range step discarded, later in-range steps still kept
// R24 - Report event if total nonzero, double event if count nonzero
// R25 - Interrupt high while any flag set with its mask bit set
`timescale 1ns/1ps
`default_nettype none
module qdc_top
    import qdc_pkg::*;
#(
    parameter int PIN_N    = 32,
    parameter int DBL_W    = 4,
    parameter int BASE_CYC = SAMPLE_BASE_CYC
)(
    input  wire logic             CLK,
    input  wire logic             RESET_N,
    input  wire logic [11:0]      ADDRESS,
    input  wire logic             READ,
    input  wire logic             WRITE,
    input  wire logic [31:0]      WRITEDATA,
    output var  logic [31:0]      READDATA,
    output var  logic             WAITREQUEST,
    input  wire logic [PIN_N-1:0] PIN_IN,
    input  wire logic [PIN_N-1:0] GPIO_OUT,
    input  wire logic [PIN_N-1:0] GPIO_OE,
    output var  logic [PIN_N-1:0] PIN_OUT,
    output var  logic [PIN_N-1:0] PIN_OE,
    output var  logic [PIN_N-1:0] PIN_OWNED,
    output var  logic             IRQ
);
    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic        acc_ok;
    logic        wr;
    logic [31:0] rd_mux;
    // One wait cycle per access: the answer always comes at the 2nd edge
    assign acc_ok = (READ | WRITE) & ~WAITREQUEST;
    assign wr     = WRITE & ~WAITREQUEST;

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            WAITREQUEST <= 1'b1;
        else if (!WAITREQUEST)
            WAITREQUEST <= 1'b1;
        else
            WAITREQUEST <= ~(READ | WRITE);
    end

    logic             on_reg;
    logic             lamp_pol;
    logic             filter_on;
    logic [3:0]       sample_iv;
    logic [3:0]       report_iv;
    logic [LEAD_W-1:0] lead;
    logic [LNK_W-1:0] links;
    logic [EV_N-1:0]  mask;
    logic [31:0]      sel_lamp;
    logic [31:0]      sel_one;
    logic [31:0]      sel_two;

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            on_reg    <= 1'b0;
            lamp_pol  <= 1'b0;
            filter_on <= 1'b0;
            sample_iv <= SAMPLE_IV_RESET;
            report_iv <= REPORT_IV_RESET;
            lead      <= LEAD_RESET;
            links     <= '0;
            sel_lamp  <= SEL_RESET;
            sel_one   <= SEL_RESET;
            sel_two   <= SEL_RESET;
        end
        else if (wr)
        begin
            case (ADDRESS)
                // R17 enable
                OFS_ON:        on_reg    <= WRITEDATA[0];
                OFS_LAMP_POL:  lamp_pol  <= WRITEDATA[0];
                OFS_FILTER:    filter_on <= WRITEDATA[0];
                OFS_SAMPLE_IV: sample_iv <= WRITEDATA[3:0];
                OFS_REPORT_IV: report_iv <= WRITEDATA[3:0];
                OFS_LEAD:      lead      <= WRITEDATA[LEAD_W-1:0];
                OFS_LINKS:     links     <= WRITEDATA[LNK_W-1:0];
                OFS_SEL_LAMP:  sel_lamp  <= WRITEDATA;
                OFS_SEL_ONE:   sel_one   <= WRITEDATA;
                OFS_SEL_TWO:   sel_two   <= WRITEDATA;
                default:       ;
            endcase
        end
    end

    // R25 mask set and clear
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            mask <= '0;
        else if (wr && ADDRESS == OFS_MASK_SET)
            mask <= mask | WRITEDATA[EV_N-1:0];
        else if (wr && ADDRESS == OFS_MASK_CLR)
            mask <= mask & ~WRITEDATA[EV_N-1:0];
    end

    // ****************************************************************
    // Tasks from software or shortcuts
    // ****************************************************************
    qdc_evt_t ev;
    qdc_evt_t flags;
    logic     t_start;
    logic     t_stop;
    logic     t_both;
    logic     t_mot;
    logic     t_dbl;

    // R16 shortcuts fire tasks from event pulses
    assign t_start = wr && ADDRESS == OFS_START && WRITEDATA[0];
    assign t_stop  = (wr && ADDRESS == OFS_STOP && WRITEDATA[0])
                   | (links[LNK_SMP_STOP] & ev.sample)
                   | (links[LNK_REP_STOP] & ev.report)
                   | (links[LNK_DBL_STOP] & ev.double_seen);
    assign t_both  = (wr && ADDRESS == OFS_SNAP_BOTH && WRITEDATA[0])
                   | (links[LNK_REP_BOTH] & ev.report);
    assign t_mot   = (wr && ADDRESS == OFS_SNAP_MOT && WRITEDATA[0])
                   | (links[LNK_REP_MOT] & ev.report);
    assign t_dbl   = (wr && ADDRESS == OFS_SNAP_DBL && WRITEDATA[0])
                   | (links[LNK_DBL_DBL] & ev.double_seen);

    qdc_run_t run;
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            run <= QDC_IDLE;
        else
        begin
            case (run)
                // R7 start
                QDC_IDLE: if (t_start && on_reg && !t_stop) run <= QDC_RUN;
                // R8 stop halts
                QDC_RUN:  if (t_stop || !on_reg) run <= QDC_IDLE;
                default:  run <= QDC_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Pin ownership
    // ****************************************************************
    logic [PIN_N-1:0] pin_s1;
    logic [PIN_N-1:0] pin_s2;
    always_ff @(posedge CLK)
    begin
        pin_s1 <= PIN_IN;
        pin_s2 <= pin_s1;
    end

    logic lamp_lvl;
    logic lamp_con;
    logic one_con;
    logic two_con;
    // R2 disconnected selects take no pin; R3 only while enabled
    assign lamp_con = on_reg & ~sel_lamp[SEL_CONNECT_BIT];
    assign one_con  = on_reg & ~sel_one[SEL_CONNECT_BIT];
    assign two_con  = on_reg & ~sel_two[SEL_CONNECT_BIT];

    logic [PIN_N-1:0] lamp_hot;
    logic [PIN_N-1:0] take;
    assign lamp_hot = lamp_con ? PIN_N'(1) << sel_lamp[SEL_PIN_W-1:0] : '0;
    assign take     = lamp_hot
                    | (one_con ? PIN_N'(1) << sel_one[SEL_PIN_W-1:0] : '0)
                    | (two_con ? PIN_N'(1) << sel_two[SEL_PIN_W-1:0] : '0);

    // R1 pin routing; R4 others follow general-purpose logic
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            PIN_OUT   <= '0;
            PIN_OE    <= '0;
            PIN_OWNED <= '0;
        end
        else
        begin
            PIN_OUT   <= (GPIO_OUT & ~take) | (lamp_hot & {PIN_N{lamp_lvl}});
            PIN_OE    <= (GPIO_OE & ~take) | lamp_hot;
            PIN_OWNED <= take;
        end
    end

    logic ph_one;
    logic ph_two;
    // Disconnected phases read as low
    assign ph_one = one_con & pin_s2[sel_one[SEL_PIN_W-1:0]];
    assign ph_two = two_con & pin_s2[sel_two[SEL_PIN_W-1:0]];

    // ****************************************************************
    // Sample timing and lamp
    // ****************************************************************
    logic [31:0] tick_cnt;
    logic [31:0] period;
    logic [31:0] lead_cyc;
    logic        tick;
    assign period   = 32'(BASE_CYC) << sample_iv;
    assign lead_cyc = 32'(lead) * 32'(LEAD_UNIT_CYC);
    assign tick     = (run == QDC_RUN) && (tick_cnt == period - 32'd1);

    // R7 sample instants every period
    always_ff @(posedge CLK)
    begin
        if (!RESET_N || run != QDC_RUN || tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 32'd1;
    end

    // R18 lamp lead time; R19 polarity. Filter needs lamp always on.
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            lamp_lvl <= 1'b0;
        else if (run == QDC_RUN &&
                 (filter_on || period - tick_cnt <= lead_cyc + 32'd1))
            lamp_lvl <= lamp_pol;
        else
            lamp_lvl <= ~lamp_pol;
    end

    // R20 debounce: accept a phase only if steady for a whole period
    logic [1:0] raw_prev;
    logic [1:0] steady;
    logic [1:0] filt;
    logic [1:0] in_now;
    assign in_now = {ph_one, ph_two};
    always_ff @(posedge CLK)
    begin
        raw_prev <= in_now;
        if (!RESET_N)
        begin
            steady <= 2'b11;
            filt   <= 2'b00;
        end
        else if (tick)
        begin
            for (int k = 0; k < 2; k++)
                if (steady[k]) filt[k] <= in_now[k];
            steady <= 2'b11;
        end
        else
            steady <= steady & ~(raw_prev ^ in_now);
    end

    // ****************************************************************
    // Decoding and accumulation
    // ****************************************************************
    logic [1:0] cur;
    logic [1:0] prev;
    logic [1:0] g_cur;
    logic [1:0] g_prev;
    logic [1:0] step;
    assign cur    = filter_on ? filt : in_now;
    assign g_cur  = {cur[1], cur[1] ^ cur[0]};
    assign g_prev = {prev[1], prev[1] ^ prev[0]};
    // R21 gray difference: 1 up, 3 down, 2 double
    assign step   = 2'(g_cur - g_prev);

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            prev <= 2'b00;
        else if (tick || run != QDC_RUN)
            prev <= cur;
    end

    logic signed [31:0] latest;
    logic signed [31:0] total;
    logic signed [31:0] total_snap;
    logic signed [31:0] next_total;
    logic [DBL_W-1:0]   dbl;
    logic [DBL_W-1:0]   dbl_snap;
    logic [DBL_W-1:0]   next_dbl;
    logic               mot_ovf;
    logic               dbl_ovf;
    logic               up;
    logic               down;
    logic               dstep;
    assign up    = tick && step == 2'd1;
    assign down  = tick && step == 2'd3;
    assign dstep = tick && step == 2'd2;
    // R23 discard step past the range
    assign mot_ovf = (up && total == 32'sh7FFF_FFFF) ||
                     (down && total == 32'sh8000_0000);
    assign dbl_ovf = dstep && (&dbl);

    // R12 a cleared total keeps only this cycle's sample
    always_comb
    begin
        next_total = (t_both || t_mot) ? 32'sd0 : total;
        next_dbl   = (t_both || t_dbl) ? '0 : dbl;
        // R22 steps go to the total, doubles to the count
        if (!mot_ovf && up)
            next_total = next_total + 32'sd1;
        else if (!mot_ovf && down)
            next_total = next_total - 32'sd1;
        if (!dbl_ovf && dstep)
            next_dbl = next_dbl + DBL_W'(1);
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            total <= '0;
            dbl   <= '0;
        end
        else
        begin
            total <= next_total;
            dbl   <= next_dbl;
        end
    end

    // R9 both snapshots; R10 motion only; R11 double only
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            total_snap <= '0;
            dbl_snap   <= '0;
        end
        else
        begin
            if (t_both || t_mot) total_snap <= total;
            if (t_both || t_dbl) dbl_snap   <= dbl;
        end
    end

    // R21 latest sample value
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            latest <= '0;
        else if (tick)
            latest <= up ? 32'sd1 : down ? -32'sd1 :
                      dstep ? 32'sd2 : 32'sd0;
    end

    // R14 report interval as sample count
    logic [8:0] rep_len;
    logic [8:0] rep_cnt;
    always_comb
    begin
        case (report_iv)
            4'h0:    rep_len = 9'd10;
            4'h1:    rep_len = 9'd40;
            4'h2:    rep_len = 9'd80;
            4'h3:    rep_len = 9'd120;
            4'h4:    rep_len = 9'd160;
            4'h5:    rep_len = 9'd200;
            4'h6:    rep_len = 9'd240;
            4'h7:    rep_len = 9'd280;
            default: rep_len = 9'd1;
        endcase
    end

    logic rep_due;
    assign rep_due = tick && rep_cnt == rep_len - 9'd1;
    always_ff @(posedge CLK)
    begin
        if (!RESET_N || run != QDC_RUN || rep_due)
            rep_cnt <= '0;
        else if (tick)
            rep_cnt <= rep_cnt + 9'd1;
    end

    // ****************************************************************
    // Events, flags and interrupt
    // ****************************************************************
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            ev <= '0;
        else
        begin
            // R13 each new sample
            ev.sample      <= tick;
            // R24 report only when total nonzero
            ev.report      <= rep_due && next_total != 32'sd0;
            // R24 double event only when count nonzero
            ev.double_seen <= rep_due && next_dbl != '0;
            // R15 either total would overflow
            ev.overflow    <= mot_ovf || dbl_ovf;
            // R8 halted flag
            ev.halted      <= run == QDC_RUN && (t_stop || !on_reg);
        end
    end

    // Hardware set wins over a software write in the same cycle
    always_ff @(posedge CLK)
    begin
        for (int e = 0; e < EV_N; e++)
        begin
            if (!RESET_N)
                flags[e] <= 1'b0;
            else if (ev[e])
                flags[e] <= 1'b1;
            else if (wr && ADDRESS == OFS_EV_SAMPLE + 12'(4 * e))
                flags[e] <= WRITEDATA[0];
        end
    end

    // R25 masked flags drive the interrupt
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            IRQ <= 1'b0;
        else
            IRQ <= |(flags & mask);
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_comb
    begin
        rd_mux = '0;
        case (ADDRESS)
            OFS_EV_SAMPLE:  rd_mux[0] = flags.sample;
            OFS_EV_REPORT:  rd_mux[0] = flags.report;
            OFS_EV_OVF:     rd_mux[0] = flags.overflow;
            OFS_EV_DBL:     rd_mux[0] = flags.double_seen;
            OFS_EV_HALT:    rd_mux[0] = flags.halted;
            OFS_LINKS:      rd_mux[LNK_W-1:0] = links;
            OFS_MASK_SET,
            OFS_MASK_CLR:   rd_mux[EV_N-1:0] = mask;
            OFS_ON:         rd_mux[0] = on_reg;
            OFS_LAMP_POL:   rd_mux[0] = lamp_pol;
            OFS_SAMPLE_IV:  rd_mux[3:0] = sample_iv;
            OFS_LATEST:     rd_mux = latest;
            OFS_REPORT_IV:  rd_mux[3:0] = report_iv;
            OFS_TOTAL:      rd_mux = total;
            OFS_TOTAL_SNAP: rd_mux = total_snap;
            OFS_SEL_LAMP:   rd_mux = sel_lamp;
            OFS_SEL_ONE:    rd_mux = sel_one;
            OFS_SEL_TWO:    rd_mux = sel_two;
            OFS_FILTER:     rd_mux[0] = filter_on;
            OFS_LEAD:       rd_mux[LEAD_W-1:0] = lead;
            OFS_DBL:        rd_mux[DBL_W-1:0] = dbl;
            OFS_DBL_SNAP:   rd_mux[DBL_W-1:0] = dbl_snap;
            default:        rd_mux = '0;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            READDATA <= '0;
        else if (READ && WAITREQUEST)
            READDATA <= rd_mux;
    end
endmodule
`default_nettype wire

// >>> rtl/qdc_pkg.sv
// Constants, register map and carrier types of the quadrature decoder
package qdc_pkg;
    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [11:0] OFS_START      = 12'h000;
    localparam logic [11:0] OFS_STOP       = 12'h004;
    localparam logic [11:0] OFS_SNAP_BOTH  = 12'h008;
    localparam logic [11:0] OFS_SNAP_MOT   = 12'h00C;
    localparam logic [11:0] OFS_SNAP_DBL   = 12'h010;
    localparam logic [11:0] OFS_EV_SAMPLE  = 12'h100;
    localparam logic [11:0] OFS_EV_REPORT  = 12'h104;
    localparam logic [11:0] OFS_EV_OVF     = 12'h108;
    localparam logic [11:0] OFS_EV_DBL     = 12'h10C;
    localparam logic [11:0] OFS_EV_HALT    = 12'h110;
    localparam logic [11:0] OFS_LINKS      = 12'h200;
    localparam logic [11:0] OFS_MASK_SET   = 12'h304;
    localparam logic [11:0] OFS_MASK_CLR   = 12'h308;
    localparam logic [11:0] OFS_ON         = 12'h500;
    localparam logic [11:0] OFS_LAMP_POL   = 12'h504;
    localparam logic [11:0] OFS_SAMPLE_IV  = 12'h508;
    localparam logic [11:0] OFS_LATEST     = 12'h50C;
    localparam logic [11:0] OFS_REPORT_IV  = 12'h510;
    localparam logic [11:0] OFS_TOTAL      = 12'h514;
    localparam logic [11:0] OFS_TOTAL_SNAP = 12'h518;
    localparam logic [11:0] OFS_SEL_LAMP   = 12'h51C;
    localparam logic [11:0] OFS_SEL_ONE    = 12'h520;
    localparam logic [11:0] OFS_SEL_TWO    = 12'h524;
    localparam logic [11:0] OFS_FILTER     = 12'h528;
    localparam logic [11:0] OFS_LEAD       = 12'h540;
    localparam logic [11:0] OFS_DBL        = 12'h544;
    localparam logic [11:0] OFS_DBL_SNAP   = 12'h548;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int          SEL_CONNECT_BIT = 31;
    localparam int          SEL_PIN_W       = 5;
    localparam logic [31:0] SEL_RESET       = 32'hFFFF_FFFF;
    localparam logic [3:0]  SAMPLE_IV_RESET = 4'h0;
    localparam logic [3:0]  REPORT_IV_RESET = 4'h0;
    localparam logic [8:0]  LEAD_RESET      = 9'h010;
    localparam int          LEAD_W          = 9;
    // Event order in flags, mask and interrupt bits
    localparam int          EV_N            = 5;
    // Shortcut bit positions
    localparam int LNK_REP_BOTH = 0;
    localparam int LNK_SMP_STOP = 1;
    localparam int LNK_REP_MOT  = 2;
    localparam int LNK_REP_STOP = 3;
    localparam int LNK_DBL_DBL  = 4;
    localparam int LNK_DBL_STOP = 5;
    localparam int LNK_W        = 6;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SAMPLE_BASE_NS = 128000;
    localparam int SAMPLE_BASE_CYC = SAMPLE_BASE_NS / CLK_PERIOD_NS;
    localparam int LEAD_UNIT_NS   = 1000;
    localparam int LEAD_UNIT_CYC  = LEAD_UNIT_NS / CLK_PERIOD_NS;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic halted;
        logic double_seen;
        logic overflow;
        logic report;
        logic sample;
    } qdc_evt_t;

    typedef enum logic {QDC_IDLE, QDC_RUN} qdc_run_t;
endpackage

// >>> testbench/qdc_monitor.sv
// Bus handshake and pin hand-over checker of the quadrature decoder
`timescale 1ns/1ps
`default_nettype none
module qdc_monitor #(parameter int PIN_N = 32)(
    input wire logic             CLK,
    input wire logic             RESET_N,
    input wire logic             READ,
    input wire logic             WRITE,
    input wire logic [31:0]      READDATA,
    input wire logic             WAITREQUEST,
    input wire logic [PIN_N-1:0] GPIO_OUT,
    input wire logic [PIN_N-1:0] GPIO_OE,
    input wire logic [PIN_N-1:0] PIN_OUT,
    input wire logic [PIN_N-1:0] PIN_OE,
    input wire logic [PIN_N-1:0] PIN_OWNED
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    logic req;
    logic wr_done;
    assign req = (READ || WRITE) && WAITREQUEST;
    assign wr_done = WRITE && !WAITREQUEST;
    sequence s_one_wait;
        !WAITREQUEST ##1 WAITREQUEST;
    endsequence
    // Pin flops follow after one clean edge past reset; the check waits for two
    sequence s_settled;
        $past(RESET_N) && $past(RESET_N, 2);
    endsequence
    chk_wait_answer: assert property (req |=> s_one_wait)
        else $error("request not answered after one wait");
    chk_wait_idle: assert property (!(READ || WRITE) |=> WAITREQUEST)
        else $error("wait released with no request");
    chk_wait_single: assert property ($fell(WAITREQUEST) |=> WAITREQUEST)
        else $error("wait low for more than one cycle");
    chk_data_hold: assert property (!(READ && WAITREQUEST)
        |=> $stable(READDATA)) else $error("read data moved unasked");
    chk_free_out: assert property (s_settled |->
        ((PIN_OUT ^ $past(GPIO_OUT)) & ~PIN_OWNED) == '0)
        else $error("free pin does not follow its output bit");
    chk_free_oe: assert property (s_settled |->
        ((PIN_OE ^ $past(GPIO_OE)) & ~PIN_OWNED) == '0)
        else $error("free pin does not follow its enable bit");
    chk_owned_count: assert property ($countones(PIN_OWNED) <= 3)
        else $error("more than three pins taken");
    chk_owned_cause: assert property (PIN_OWNED != $past(PIN_OWNED)
        |-> $past(wr_done) || $past(wr_done, 2))
        else $error("pin ownership moved without a write");
endmodule
bind qdc_top qdc_monitor #(.PIN_N(PIN_N)) u_mon (.CLK, .RESET_N, .READ,
    .WRITE, .READDATA, .WAITREQUEST, .GPIO_OUT, .GPIO_OE, .PIN_OUT,
    .PIN_OE, .PIN_OWNED);
`default_nettype wire

// >>> testbench/qdc_encoder_model.sv
// Two-phase encoder model driving the phase pins of the decoder
`timescale 1ns/1ps
`default_nettype none
module qdc_encoder_model #(
    parameter int A_PIN = 3,
    parameter int B_PIN = 4
)(
    input  wire logic        clk,
    input  wire logic [1:0]  move,
    output var  logic [31:0] pins
);
    logic [1:0] ab = 2'h0;
    // One move per pulse: 1 forward, 2 back, 3 both phases at once
    always @(posedge clk)
    begin
        case (move)
            2'h1: ab <= {ab[0], ~ab[1]};
            2'h2: ab <= {~ab[0], ab[1]};
            2'h3: ab <= ~ab;
            default: ab <= ab;
        endcase
    end
    always_comb
    begin
        pins = 32'h0000_0000;
        pins[A_PIN] = ab[1];
        pins[B_PIN] = ab[0];
    end
endmodule
`default_nettype wire

// >>> testbench/qdc_top_bench.sv
// Self-checking bench of the quadrature decoder registers and pins
`timescale 1ns/1ps
`default_nettype none
module qdc_top_bench
    import qdc_pkg::*;
;
    typedef struct packed {logic we; logic [11:0] adr; logic [7:0] dat;
                           logic [31:0] exp;} qdc_row_t;
    logic        CLK = 1'h0;
    logic        RESET_N = 1'h0;
    logic        READ = 1'h0;
    logic        WRITE = 1'h0;
    logic        WAITREQUEST;
    logic        IRQ;
    logic [1:0]  mv = 2'h0;
    logic [11:0] ADDRESS = 12'h000;
    logic [31:0] WRITEDATA = 32'h0000_0000;
    logic [31:0] GPIO_OUT = 32'h0000_0000;
    logic [31:0] GPIO_OE = 32'h0000_0000;
    logic [31:0] READDATA, PIN_IN, PIN_OUT, PIN_OE, PIN_OWNED, q;
    int          err_count = 0;
    int          cmp_count = 0;
    qdc_row_t rows [10] = '{
        '{1'h0, OFS_SEL_LAMP, 8'h00, 32'hFFFF_FFFF},
        '{1'h0, OFS_LEAD, 8'h00, 32'h0000_0010},
        '{1'h0, OFS_REPORT_IV, 8'h00, 32'h0000_0000},
        '{1'h1, OFS_LAMP_POL, 8'h01, 32'h0000_0001},
        '{1'h1, OFS_FILTER, 8'h01, 32'h0000_0001},
        '{1'h1, OFS_FILTER, 8'h00, 32'h0000_0000},
        '{1'h1, 12'h600, 8'h05, 32'h0000_0000},
        '{1'h1, OFS_TOTAL, 8'h07, 32'h0000_0000},
        '{1'h1, OFS_MASK_SET, 8'h15, 32'h0000_0015},
        '{1'h1, OFS_MASK_CLR, 8'h05, 32'h0000_0010}
    };
    qdc_top #(.BASE_CYC(8)) DUT (.CLK, .RESET_N, .ADDRESS, .READ, .WRITE,
        .WRITEDATA, .READDATA, .WAITREQUEST, .PIN_IN, .GPIO_OUT, .GPIO_OE,
        .PIN_OUT, .PIN_OE, .PIN_OWNED, .IRQ);
    qdc_encoder_model #(.A_PIN(3), .B_PIN(4)) enc (.clk(CLK), .move(mv),
        .pins(PIN_IN));
    always #5 CLK = ~CLK;
    task automatic conclude;
        if (err_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Held until wait is seen low; one idle edge keeps drives apart
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        ADDRESS <= a;
        WRITEDATA <= d;
        READ <= !w;
        WRITE <= w;
        @(posedge CLK);
        while (WAITREQUEST !== 1'h0 && n < 40)
        begin
            n++;
            @(posedge CLK);
        end
        if (n == 40)
            err_count++;
        q = READDATA;
        READ <= 1'h0;
        WRITE <= 1'h0;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), e, q);
    endtask
    // Three sample periods per move so one tick sees each change
    task automatic step(input logic [1:0] m);
        mv <= m;
        @(posedge CLK);
        mv <= 2'h0;
        repeat (24) @(posedge CLK);
    endtask
    initial
    begin
        repeat (5000) @(posedge CLK);
        err_count++;
        conclude();
    end
    initial
    begin
        repeat (4) @(posedge CLK);
        RESET_N <= 1'h1;
        @(posedge CLK);
        foreach (rows[i])
        begin
            if (rows[i].we)
                bus(1'h1, rows[i].adr, 32'(rows[i].dat));
            rd(rows[i].adr, rows[i].exp);
        end
        GPIO_OUT <= 32'hA5A5_0F0F;
        GPIO_OE <= 32'h0000_FFC7;
        repeat (2) @(posedge CLK);
        chk("pin_out", 32'hA5A5_0F0F, PIN_OUT);
        bus(1'h1, OFS_SEL_LAMP, 32'h0000_0005);
        bus(1'h1, OFS_SEL_ONE, 32'h0000_0003);
        bus(1'h1, OFS_SEL_TWO, 32'h0000_0004);
        bus(1'h1, OFS_LAMP_POL, 32'h0000_0000);
        chk("pin_owned", 32'h0000_0000, PIN_OWNED);
        bus(1'h1, OFS_ON, 32'h0000_0001);
        repeat (2) @(posedge CLK);
        chk("pin_owned", 32'h0000_0038, PIN_OWNED);
        chk("pin_oe", 32'h0000_FFE7, PIN_OE);
        chk("pin_out", 32'hA5A5_0F27, PIN_OUT & 32'hFFFF_FFE7);
        bus(1'h1, OFS_START, 32'h0000_0001);
        step(2'h1);
        step(2'h1);
        step(2'h2);
        step(2'h3);
        rd(OFS_TOTAL, 32'h0000_0001);
        rd(OFS_DBL, 32'h0000_0001);
        rd(OFS_EV_SAMPLE, 32'h0000_0001);
        rd(OFS_EV_REPORT, 32'h0000_0001);
        bus(1'h1, OFS_SNAP_BOTH, 32'h0000_0001);
        rd(OFS_TOTAL_SNAP, 32'h0000_0001);
        rd(OFS_DBL_SNAP, 32'h0000_0001);
        rd(OFS_TOTAL, 32'h0000_0000);
        rd(OFS_DBL, 32'h0000_0000);
        step(2'h1);
        step(2'h1);
        step(2'h3);
        bus(1'h1, OFS_SNAP_MOT, 32'h0000_0001);
        rd(OFS_TOTAL_SNAP, 32'h0000_0002);
        rd(OFS_TOTAL, 32'h0000_0000);
        rd(OFS_DBL, 32'h0000_0001);
        bus(1'h1, OFS_SNAP_DBL, 32'h0000_0001);
        rd(OFS_DBL_SNAP, 32'h0000_0001);
        rd(OFS_DBL, 32'h0000_0000);
        bus(1'h1, OFS_STOP, 32'h0000_0001);
        rd(OFS_EV_HALT, 32'h0000_0001);
        chk("irq", 32'h0000_0001, 32'(IRQ));
        bus(1'h1, OFS_EV_HALT, 32'h0000_0000);
        @(posedge CLK);
        chk("irq", 32'h0000_0000, 32'(IRQ));
        conclude();
    end
endmodule
`default_nettype wire
